// File: inc/afr_consts.vh
// Constants for the accelerometer front-end result register bank.
`ifndef AFR_CONSTS_VH
`define AFR_CONSTS_VH

// Register byte offsets (MSB byte at the even offset, LSB at offset plus one).
`define AFR_OFS_STAGE1_X    8'h06
`define AFR_OFS_STAGE1_Y    8'h08
`define AFR_OFS_STAGE1_Z    8'h0A
`define AFR_OFS_MAG_X       8'h0C
`define AFR_OFS_MAG_Y       8'h0E
`define AFR_OFS_MAG_Z       8'h10
`define AFR_OFS_RAW_X       8'h12
`define AFR_OFS_RAW_Y       8'h14
`define AFR_OFS_RAW_Z       8'h16
`define AFR_OFS_RESULT_LAST 8'h17
`define AFR_OFS_FE_CTRL     8'h30

// Result storage: word index is the byte offset divided by two.
`define AFR_WORD_FIRST      4'h3
`define AFR_WORD_COUNT      4'h9
`define AFR_WORD_LAST       4'h8

// Front-end control register fields and reset values.
`define AFR_FS_LSB          0
`define AFR_FS_MSB          1
`define AFR_FS_2G           2'h0
`define AFR_FS_4G           2'h1
`define AFR_FS_8G           2'h2
`define AFR_FE_CTRL_RESET   8'h00
`define AFR_RESULT_RESET    16'h0000

// Range limits of the scaled results.
`define AFR_LIM_4G          16'h2000
`define AFR_LIM_8G          16'h1000
`define AFR_LIM_MAG         16'h7FFF

// Timing: 488 Hz raw rate and 244 Hz second-stage rate from a 50 MHz clock.
`define AFR_CLK_HZ          50000000
`define AFR_RAW_RATE_HZ     488
`define AFR_RAW_DIV         (`AFR_CLK_HZ / `AFR_RAW_RATE_HZ)

`endif

// File: verilog/afr_result_mem.v
// Result word storage with a registered byte read port.
`timescale 1ns/100ps
`include "afr_consts.vh"

module afr_result_mem (
  input  wire        clock,     // System clock.
  input  wire        srst,      // Synchronous reset, clears every word.
  input  wire        wrEn,      // Word write strobe.
  input  wire [3:0]  wrIdx,     // Word index to write.
  input  wire [15:0] wrData,    // Word to store.
  input  wire        rdEn,      // Byte read strobe.
  input  wire        rdHit,     // Read address falls in the result words.
  input  wire [3:0]  rdIdx,     // Word index to read.
  input  wire        rdLow,     // High selects the low byte.
  input  wire [7:0]  altByte,   // Byte returned when the read misses the words.
  output reg  [7:0]  rdByte     // Registered read data.
);

  reg [15:0] mem_q [0:15];
  integer    i;

  always @(posedge clock) begin
    if (srst) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem_q[i] <= `AFR_RESULT_RESET;
      end
    end else if (wrEn) begin
      mem_q[wrIdx] <= wrData;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      rdByte <= 8'h00;
    end else if (rdEn) begin
      if (!rdHit) begin
        rdByte <= altByte;
      end else if (rdLow) begin
        rdByte <= mem_q[rdIdx][7:0];
      end else begin
        rdByte <= mem_q[rdIdx][15:8];
      end
    end
  end

endmodule

// File: verilog/afr_result_bank.v
// Accelerometer front-end result bank: scaling, magnitude, decimation and register access.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "afr_consts.vh"

// Functional notes
// - Second-stage results refresh at 244 Hz, two-sample average limits bandwidth.
// - Second-stage results are signed 16-bit at 0.244 mg per count.
// - Magnitude results hold absolute normalized 488 Hz samples at 0.244 mg.
// - Magnitude results never go negative and stay within 0 to 32767.
// - Raw results refresh at 488 Hz from unnormalized samples.
// - Full-scale select in the control register sets raw result resolution.
// - In 2g range raw results are 0.061 mg per count, full 16-bit span.
// - In 4g range raw results are 0.122 mg per count, clamped to 8192.
// - In 8g range raw results are 0.244 mg per count, clamped to 4096.
module afr_result_bank #(
  parameter SAMPLE_DIV = `AFR_RAW_DIV  // Clock cycles per 488 Hz sample.
) (
  input  wire        clock,       // 50 MHz system clock.
  input  wire        srst,        // Synchronous reset, active high.
  input  wire [7:0]  regAddr,     // Register byte address.
  input  wire [7:0]  regWrData,   // Register write data.
  input  wire        regWrStb,    // Register write strobe.
  input  wire        regRdStb,    // Register read strobe.
  output wire [7:0]  regRdData,   // Read data, valid the cycle after the strobe.
  input  wire [15:0] sensorX,     // X acceleration, signed, 0.061 mg per count.
  input  wire [15:0] sensorY,     // Y acceleration, signed, 0.061 mg per count.
  input  wire [15:0] sensorZ,     // Z acceleration, signed, 0.061 mg per count.
  output wire        sampleTick,  // One-cycle pulse when a 488 Hz sample is taken.
  output wire [1:0]  fullScaleSel // Current full-scale range selection.
);

  localparam ST_IDLE  = 2'h1;
  localparam ST_WRITE = 2'h2;

  // Clamp a signed value to the symmetric range minus lim through lim.
  function signed [15:0] clampSym;
    input signed [15:0] v;
    input signed [15:0] lim;
    begin
      if (v > lim) begin
        clampSym = lim;
      end else if (v < -lim) begin
        clampSym = -lim;
      end else begin
        clampSym = v;
      end
    end
  endfunction

  reg  [19:0]  divCnt_q;
  reg          tick_q;
  reg          halfPhase_q;
  reg  [7:0]   feCtrl_q;
  reg  [1:0]   state_q;
  reg  [3:0]   wrCnt_q;
  reg  [143:0] stage_q;
  reg  [47:0]  prevNorm_q;
  wire [47:0]  sensorAll;
  wire [47:0]  normAll;
  wire [47:0]  magAll;
  wire [47:0]  rawAll;
  wire [47:0]  avgAll;
  wire [1:0]   fsSel;
  wire         rdHit;
  wire [7:0]   altByte;

  assign sensorAll    = {sensorZ, sensorY, sensorX};
  assign fsSel        = feCtrl_q[`AFR_FS_MSB:`AFR_FS_LSB];
  assign fullScaleSel = fsSel;
  assign sampleTick   = tick_q;

  // Sample-rate divider; the 244 Hz phase toggles on every 488 Hz tick.
  always @(posedge clock) begin
    if (srst) begin
      divCnt_q    <= 20'h00000;
      tick_q      <= 1'h0;
      halfPhase_q <= 1'h0;
    end else begin
      tick_q <= 1'h0;
      if (divCnt_q == SAMPLE_DIV[19:0] - 20'h00001) begin
        divCnt_q    <= 20'h00000;
        tick_q      <= 1'h1;
        halfPhase_q <= ~halfPhase_q;
      end else begin
        divCnt_q <= divCnt_q + 20'h00001;
      end
    end
  end

  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1) begin : gAxis
      wire signed [15:0] s;
      wire signed [15:0] norm;
      wire signed [15:0] prev;
      wire signed [16:0] sum;
      reg  signed [15:0] raw;
      assign s    = sensorAll[a*16 +: 16];
      assign norm = s >>> 2;
      assign prev = prevNorm_q[a*16 +: 16];
      assign sum  = {prev[15], prev} + {norm[15], norm};
      assign avgAll[a*16 +: 16] = sum[16:1];
      assign normAll[a*16 +: 16] = norm;
      // Absolute value, clamped so the result is never negative.
      assign magAll[a*16 +: 16] = clampSym(norm[15] ? -norm : norm,
                                           `AFR_LIM_MAG);
      always @* begin
        case (fsSel)
          `AFR_FS_2G: raw = s;
          `AFR_FS_4G: raw = clampSym(s >>> 1, `AFR_LIM_4G);
          `AFR_FS_8G: raw = clampSym(s >>> 2, `AFR_LIM_8G);
          default:    raw = clampSym(s >>> 2, `AFR_LIM_8G);
        endcase
      end
      assign rawAll[a*16 +: 16] = raw;
    end
  endgenerate

  // On each tick latch the raw and magnitude words, the second-stage words every other tick, then copy all nine into storage one per cycle.
  always @(posedge clock) begin
    if (srst) begin
      stage_q    <= 144'h0;
      prevNorm_q <= 48'h0;
      state_q    <= ST_IDLE;
      wrCnt_q    <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tick_q) begin
            stage_q[143:48] <= {rawAll, magAll};
            prevNorm_q      <= normAll;
            if (halfPhase_q) begin
              stage_q[47:0] <= avgAll;
            end
            wrCnt_q <= 4'h0;
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (wrCnt_q == `AFR_WORD_LAST) begin
            state_q <= ST_IDLE;
          end else begin
            wrCnt_q <= wrCnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Only the control register accepts writes; result addresses ignore them.
  always @(posedge clock) begin
    if (srst) begin
      feCtrl_q <= `AFR_FE_CTRL_RESET;
    end else if (regWrStb && regAddr == `AFR_OFS_FE_CTRL) begin
      feCtrl_q <= regWrData;
    end
  end

  assign rdHit   = (regAddr >= `AFR_OFS_STAGE1_X) && (regAddr <= `AFR_OFS_RESULT_LAST);
  assign altByte = (regAddr == `AFR_OFS_FE_CTRL) ? feCtrl_q : 8'h00;

  afr_result_mem uMem (
    .clock   (clock),
    .srst    (srst),
    .wrEn    (state_q == ST_WRITE),
    .wrIdx   (wrCnt_q + `AFR_WORD_FIRST),
    .wrData  (stage_q[wrCnt_q*16 +: 16]),
    .rdEn    (regRdStb),
    .rdHit   (rdHit),
    .rdIdx   (regAddr[4:1]),
    .rdLow   (regAddr[0]),
    .altByte (altByte),
    .rdByte  (regRdData)
  );

endmodule

// File: verilog/afr_result_bank_end.v
// This file holds no logic of its own.

// File: bench/afr_result_bank_asserts.sv
// Checker for the result bank register port, control field and sample tick.
`timescale 1ns/100ps
module afr_result_bank_asserts (
  input wire       clock,        // Clock.
  input wire       srst,         // Reset.
  input wire [7:0] regAddr,      // Address.
  input wire [7:0] regWrData,    // Write data.
  input wire       regWrStb,     // Write strobe.
  input wire       regRdStb,     // Read strobe.
  input wire [7:0] regRdData,    // Read data.
  input wire       sampleTick,   // Sample pulse.
  input wire [1:0] fullScaleSel  // Range field.
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_tick_pulse: assert property (sampleTick |=> !sampleTick [*8])
    else $error("sample tick too close");
  a_ctrl_write: assert property (regWrStb && regAddr == 8'h30 |=>
    fullScaleSel == $past(regWrData[1:0])) else $error("range not taken");
  a_ctrl_hold: assert property (
    !(regWrStb && regAddr == 8'h30) |=> $stable(fullScaleSel))
    else $error("range changed alone");
  a_rd_unmapped: assert property (
    regRdStb && regAddr < 8'h06 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_ctrl: assert property (
    regRdStb && regAddr == 8'h30 |=> regRdData[1:0] == fullScaleSel)
    else $error("control readback wrong");
  a_rd_hold: assert property (!regRdStb |=> $stable(regRdData))
    else $error("read data moved");
  a_mag_sign: assert property (regRdStb && regAddr inside {8'h0C, 8'h0E, 8'h10} |=>
    !regRdData[7]) else $error("magnitude negative");
  a_reset_clear: assert property (disable iff (1'b0) srst |=>
    regRdData == 8'h00 && !sampleTick && fullScaleSel == 2'h0)
    else $error("reset state wrong");
endmodule
bind afr_result_bank afr_result_bank_asserts afr_result_bank_asserts_inst (.clock(clock),
  .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .sampleTick(sampleTick),
  .fullScaleSel(fullScaleSel));

// File: bench/tb.sv
// Self-checking bench for the accelerometer result bank.
`timescale 1ns/100ps
module tb;
  reg        clock = 1'b0;
  reg        srst = 1'b1;
  reg [7:0]  regAddr = 8'h00;
  reg [7:0]  regWrData = 8'h00;
  reg        regWrStb = 1'b0;
  reg        regRdStb = 1'b0;
  reg [15:0] sensorX = 16'h0000;
  reg [15:0] sensorY = 16'h0000;
  reg [15:0] sensorZ = 16'h0000;
  wire [7:0] regRdData;
  wire       sampleTick;
  wire [1:0] fullScaleSel;
  int        n_mismatch = 0;
  int        n_compared = 0;
  int        words[9];
  int        prevN[3];
  int        ticks = 0;
  int        s, n, fs, ctl, i, k;
  always #10 clock = ~clock;
  afr_result_bank #(.SAMPLE_DIV(64)) afr_result_bank_inst (.clock(clock), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .sensorX(sensorX), .sensorY(sensorY), .sensorZ(sensorZ),
    .sampleTick(sampleTick), .fullScaleSel(fullScaleSel));
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    @(negedge clock);
    chk(regRdData, exp);
  endtask
  function int clamp(int v, int l);
    return v > l ? l : (v < -l ? -l : v);
  endfunction
  // Updates the expected words from the sensor values seen at a tick.
  task sample;
    logic [15:0] sv[3];
    sv = '{sensorX, sensorY, sensorZ};
    ticks++;
    for (k = 0; k < 3; k++) begin
      s = $signed(sv[k]);
      n = s >>> 2;
      // Second-stage words follow the first tick and every second tick after it.
      if (ticks % 2 == 1) words[k] = (prevN[k] + n) >>> 1;
      prevN[k] = n;
      words[3 + k] = n < 0 ? -n : n;
      words[6 + k] = fs == 0 ? s : (fs == 1 ? clamp(s >>> 1, 8192) : clamp(n, 4096));
    end
  endtask
  initial begin
    void'($urandom(32'hFFFBE3CD));
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    wr(8'h12, 8'hFF);
    for (i = 4; i < 24; i++) rd(i[7:0], 8'h00);
    for (i = 0; i < 12; i++) begin
      fs = i % 4;
      ctl = ($urandom % 64) * 4 + fs;
      wr(8'h06 + $urandom % 18, $urandom % 256);
      wr(8'h30, ctl[7:0]);
      k = 0;
      do begin
        @(negedge clock);
        k++;
      end while (sampleTick !== 1'b1 && k < 100);
      if (sampleTick !== 1'b1) begin
        n_mismatch++;
        break;
      end
      chk({6'h00, fullScaleSel}, {6'h00, ctl[1:0]});
      sample;
      @(posedge clock);
      sensorX <= $urandom;
      sensorY <= (i == 0) ? 16'h8000 : $urandom;
      sensorZ <= $urandom;
      repeat (12) @(posedge clock);
      for (k = 0; k < 18; k++) rd(8'h06 + k, words[k / 2] >> ((k % 2) ? 0 : 8));
      rd(8'h30, ctl[7:0]);
    end
    end_sim;
  end
endmodule
